//--- hw/ecd_cfg.svh
// Constants for the external memory chip select decoder
`ifndef ECD_CFG_SVH
`define ECD_CFG_SVH

// ************************************************************
// Register offsets (byte addresses on the register port)
// ************************************************************
`define ECD_AREA_STRIDE      8'h04
`define ECD_OFS_CTRL_LOW     8'h00
`define ECD_OFS_CTRL_HIGH    8'h01
`define ECD_OFS_START        8'h02
`define ECD_OFS_MASK         8'h03
`define ECD_OFS_DEF_LOW      8'h10
`define ECD_OFS_DEF_HIGH     8'h11
`define ECD_OFS_PAGE_ROM     8'h12
`define ECD_OFS_STATUS       8'h13

// ************************************************************
// Field positions
// ************************************************************
`define ECD_HIGH_ENABLE      7
`define ECD_HIGH_WHOLE_MODE  6
`define ECD_HIGH_MTYPE_LSB   2
`define ECD_HIGH_WIDTH_LSB   0
`define ECD_LOW_WRITE_LSB    4
`define ECD_LOW_READ_LSB     0
`define ECD_HIGH_MASK        8'hcf
`define ECD_LOW_MASK         8'h77

// ************************************************************
// Reset values
// ************************************************************
`define ECD_RST_LOW          8'h22
`define ECD_RST_HIGH         8'h00
`define ECD_RST_HIGH_AREA2   8'h80
`define ECD_RST_START        8'h00
`define ECD_RST_MASK         8'h00
`define ECD_RST_PAGE_ROM     8'h00

// ************************************************************
// Field codes
// ************************************************************
`define ECD_WIDTH_8          2'h0
`define ECD_WIDTH_16         2'h1
`define ECD_MTYPE_SRAM       2'h0
`define ECD_WAIT_2ST         3'h1
`define ECD_WAIT_3ST         3'h2
`define ECD_WAIT_4ST         3'h5
`define ECD_WAIT_5ST         3'h6
`define ECD_WAIT_6ST         3'h3
`define ECD_WAIT_PIN         3'h7

// ************************************************************
// Timing
// ************************************************************
`define ECD_CLK_PERIOD_NS    50
`define ECD_MIN_CYCLE_NS     100
`define ECD_MIN_STATES       ((`ECD_MIN_CYCLE_NS + `ECD_CLK_PERIOD_NS - 1) / `ECD_CLK_PERIOD_NS)
`define ECD_PIN_BASE_STATES  3

`endif

//--- hw/ecd_pkg.sv
// Types shared by the chip select decoder files
package ecd_pkg;

   typedef enum logic {
      ECD_IDLE,
      ECD_ACTIVE
   } ecd_state_t;

   typedef logic [2:0] ecd_states_t;

endpackage

//--- hw/ecd_wait_timer.sv
// Bus cycle state counter with fixed length and wait-pin stretching
`timescale 1ns/100ps
`default_nettype none
`include "ecd_cfg.svh"

module ecd_wait_timer
   import ecd_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_start,
   input  wire ecd_states_t i_states,
   input  wire logic        i_extend,
   input  wire logic        i_wait_n,
   output logic             o_busy,
   output logic             o_done
);

   ecd_state_t  state_r;
   ecd_state_t  state_nxt;
   ecd_states_t count_r;
   ecd_states_t count_nxt;
   ecd_states_t target_r;
   ecd_states_t target_nxt;
   logic        extend_r;
   logic        extend_nxt;
   logic        last;

   // The pin can only hold the final state; it never shortens a cycle
   assign last   = (state_r == ECD_ACTIVE) && (count_r >= target_r) && !(extend_r && !i_wait_n);
   assign o_busy = (state_r == ECD_ACTIVE);
   assign o_done = last;

   always_comb begin
      state_nxt  = state_r;
      count_nxt  = count_r;
      target_nxt = target_r;
      extend_nxt = extend_r;
      case (state_r)
         ECD_IDLE: begin
            if (i_start) begin
               state_nxt  = ECD_ACTIVE;
               count_nxt  = 3'h1;
               // Never shorter than the bus minimum
               if (i_states < ecd_states_t'(`ECD_MIN_STATES)) begin
                  target_nxt = ecd_states_t'(`ECD_MIN_STATES);
               end else begin
                  target_nxt = i_states;
               end
               extend_nxt = i_extend;
            end
         end
         ECD_ACTIVE: begin
            if (last) begin
               state_nxt = ECD_IDLE;
            end else if (count_r < target_r) begin
               count_nxt = count_r + 3'h1;
            end
         end
         default: begin
            state_nxt = ECD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r  <= ECD_IDLE;
         count_r  <= 3'h0;
         target_r <= 3'h0;
         extend_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         count_r  <= count_nxt;
         target_r <= target_nxt;
         extend_r <= extend_nxt;
      end
   end

endmodule
`default_nettype wire

//--- hw/ecd_decoder.sv
// Chip select decoder: area registers, address compare and bus cycle timing
`timescale 1ns/100ps
`default_nettype none
`include "ecd_cfg.svh"

// How it works
// - Four programmable areas, each own chip select
// - Each area picks 8 or 16 bit bus
// - Six wait modes, read/write separate
// - Only area 2 enabled after reset
// - Area 2 covers everything while mode clear
// - Compare unmasked bits, assert matching select low
// - Start field gives A23..A16, 64K aligned
// - Mask bit 1 excludes, 0 includes
// - Maskable bit ranges differ per area
// - Area 1 shared bit covers A15..A9
// - Block sizes limited per area
// - Area 2 mode set uses start/mask
// - Priority: I/O, memory, areas 0..3
// - Unmatched access uses default space
// - Memory type 00 means static RAM/ROM
// - Page ROM control enables page reads
// - Width code 00 8-bit, 01 16-bit
// - Bus cycle at least two states
// - Wait codes give 2..6 fixed states
module ecd_decoder
   import ecd_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   input  wire logic        i_bus_start,
   input  wire logic [23:0] i_bus_addr,
   input  wire logic        i_bus_write,
   input  wire logic        i_int_io_hit,
   input  wire logic        i_int_mem_hit,
   input  wire logic        i_wait_n,
   output logic      [3:0]  o_area_chip_select_n,
   output logic             o_default_space_chip_select_n,
   output logic             o_bus_16bit,
   output logic      [1:0]  o_memory_type,
   output logic             o_page_rom_enable,
   output logic             o_bus_busy,
   output logic             o_bus_done
);

   // ************************************************************
   // Register file
   // ************************************************************
   logic [7:0]  area_control_low_r    [4];
   logic [7:0]  area_control_low_nxt  [4];
   logic [7:0]  area_control_high_r   [4];
   logic [7:0]  area_control_high_nxt [4];
   logic [7:0]  area_start_address_r  [4];
   logic [7:0]  area_start_address_nxt[4];
   logic [7:0]  area_address_mask_r   [4];
   logic [7:0]  area_address_mask_nxt [4];
   logic [7:0]  default_low_r;
   logic [7:0]  default_low_nxt;
   logic [7:0]  default_high_r;
   logic [7:0]  default_high_nxt;
   logic [7:0]  page_rom_control_r;
   logic [7:0]  page_rom_control_nxt;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;

   // Bus cycle state
   logic [3:0]  area_cs_n_r;
   logic [3:0]  area_cs_n_nxt;
   logic        def_cs_n_r;
   logic        def_cs_n_nxt;
   logic        width16_r;
   logic        width16_nxt;
   logic [1:0]  mtype_r;
   logic [1:0]  mtype_nxt;
   logic [2:0]  last_hit_r;
   logic [2:0]  last_hit_nxt;

   logic [3:0]  area_hit;
   logic [23:0] full_mask [4];
   logic        timer_busy;
   logic        timer_done;
   logic        accept;
   logic [7:0]  sel_low;
   logic [7:0]  sel_high;
   logic        sel_default;
   logic [2:0]  wait_code;
   ecd_states_t wait_states;
   logic        wait_pin_mode;

   // Expand the 8-bit mask into a 24-bit address mask per area
   function automatic logic [23:0] expand_mask(input int unsigned area, input logic [7:0] m);
      logic [23:0] x;
      x = 24'h000000;
      case (area)
         0: begin
            // A20..A15 individually, A14..A9 by one bit, A8 alone
            x[20:15] = m[7:2];
            x[14:9]  = {6{m[1]}};
            x[8]     = m[0];
         end
         1: begin
            x[21:16] = m[7:2];
            x[15:9]  = {7{m[1]}};
            x[8]     = m[0];
         end
         default: begin
            // Lowest block is 32K: A14..A0 never compared
            x[22:15] = m;
            x[14:0]  = 15'h7fff;
         end
      endcase
      // Areas 0 and 1 never compare below A8
      if (area < 2) begin
         x[7:0] = 8'hff;
      end
      return x;
   endfunction

   // ************************************************************
   // Address compare per area
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_area
         logic match;
         assign full_mask[g] = expand_mask(g, area_address_mask_r[g]);
         // Start field supplies A23..A16 only
         assign match = (((i_bus_addr ^ {area_start_address_r[g], 16'h0000})
                          & ~full_mask[g]) == 24'h000000);
         if (g == 2) begin : g_whole
            // Mode bit clear: whole 16M space
            assign area_hit[g] = area_control_high_r[g][`ECD_HIGH_ENABLE]
                                 && (!area_control_high_r[g][`ECD_HIGH_WHOLE_MODE]
                                     || match);
         end else begin : g_plain
            assign area_hit[g] = area_control_high_r[g][`ECD_HIGH_ENABLE] && match;
         end
      end
   endgenerate

   // ************************************************************
   // Priority select and wait setting
   // ************************************************************
   logic [1:0] sel_idx;
   always_comb begin
      sel_idx     = 2'h0;
      sel_default = 1'b0;
      // Built-in regions win over every area
      if (i_int_io_hit || i_int_mem_hit) begin
         sel_default = 1'b0;
      end else if (area_hit[0]) begin
         sel_idx = 2'h0;
      end else if (area_hit[1]) begin
         sel_idx = 2'h1;
      end else if (area_hit[2]) begin
         sel_idx = 2'h2;
      end else if (area_hit[3]) begin
         sel_idx = 2'h3;
      end else begin
         sel_default = 1'b1;
      end
   end

   assign sel_low  = sel_default ? default_low_r  : area_control_low_r[sel_idx];
   assign sel_high = sel_default ? default_high_r : area_control_high_r[sel_idx];
   assign wait_code = i_bus_write ? sel_low[`ECD_LOW_WRITE_LSB +: 3]
                                  : sel_low[`ECD_LOW_READ_LSB +: 3];

   always_comb begin
      wait_pin_mode = 1'b0;
      case (wait_code)
         `ECD_WAIT_2ST: wait_states = 3'h2;
         `ECD_WAIT_3ST: wait_states = 3'h3;
         `ECD_WAIT_4ST: wait_states = 3'h4;
         `ECD_WAIT_5ST: wait_states = 3'h5;
         `ECD_WAIT_6ST: wait_states = 3'h6;
         `ECD_WAIT_PIN: begin
            wait_states   = ecd_states_t'(`ECD_PIN_BASE_STATES);
            wait_pin_mode = 1'b1;
         end
         // Reserved codes fall back to the default length
         default: wait_states = 3'h3;
      endcase
   end

   // Internal regions are not external cycles, so no timer run
   assign accept = i_bus_start && !timer_busy && !(i_int_io_hit || i_int_mem_hit);

   ecd_wait_timer u_timer (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_start   (accept),
      .i_states  (wait_states),
      .i_extend  (wait_pin_mode),
      .i_wait_n  (i_wait_n),
      .o_busy    (timer_busy),
      .o_done    (timer_done)
   );

   // ************************************************************
   // Chip selects held for the whole bus cycle
   // ************************************************************
   always_comb begin
      area_cs_n_nxt = area_cs_n_r;
      def_cs_n_nxt  = def_cs_n_r;
      width16_nxt   = width16_r;
      mtype_nxt     = mtype_r;
      last_hit_nxt  = last_hit_r;
      if (accept) begin
         area_cs_n_nxt = 4'hf;
         def_cs_n_nxt  = !sel_default;
         if (!sel_default) begin
            area_cs_n_nxt[sel_idx] = 1'b0;
         end
         // Reserved width codes act as 8-bit
         width16_nxt  = (sel_high[`ECD_HIGH_WIDTH_LSB +: 2] == `ECD_WIDTH_16);
         mtype_nxt    = sel_high[`ECD_HIGH_MTYPE_LSB +: 2];
         last_hit_nxt = sel_default ? 3'h4 : {1'b0, sel_idx};
      end else if (timer_done) begin
         area_cs_n_nxt = 4'hf;
         def_cs_n_nxt  = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         area_cs_n_r <= 4'hf;
         def_cs_n_r  <= 1'b1;
         width16_r   <= 1'b0;
         mtype_r     <= `ECD_MTYPE_SRAM;
         last_hit_r  <= 3'h0;
      end else begin
         area_cs_n_r <= area_cs_n_nxt;
         def_cs_n_r  <= def_cs_n_nxt;
         width16_r   <= width16_nxt;
         mtype_r     <= mtype_nxt;
         last_hit_r  <= last_hit_nxt;
      end
   end

   // ************************************************************
   // Register writes and reads
   // ************************************************************
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         area_control_low_nxt[n]   = area_control_low_r[n];
         area_control_high_nxt[n]  = area_control_high_r[n];
         area_start_address_nxt[n] = area_start_address_r[n];
         area_address_mask_nxt[n]  = area_address_mask_r[n];
      end
      default_low_nxt      = default_low_r;
      default_high_nxt     = default_high_r;
      page_rom_control_nxt = page_rom_control_r;
      rdata_nxt            = 8'h00;
      if (i_reg_wr) begin
         for (int n = 0; n < 4; n++) begin
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_CTRL_LOW) begin
               area_control_low_nxt[n] = i_reg_wdata & `ECD_LOW_MASK;
            end
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_CTRL_HIGH) begin
               // Only area 2 has the whole-space mode bit
               area_control_high_nxt[n] = i_reg_wdata & `ECD_HIGH_MASK
                  & ((n == 2) ? 8'hff : ~(8'h01 << `ECD_HIGH_WHOLE_MODE));
            end
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_START) begin
               area_start_address_nxt[n] = i_reg_wdata;
            end
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_MASK) begin
               area_address_mask_nxt[n] = i_reg_wdata;
            end
         end
         case (i_reg_addr)
            `ECD_OFS_DEF_LOW:  default_low_nxt      = i_reg_wdata & `ECD_LOW_MASK;
            `ECD_OFS_DEF_HIGH: default_high_nxt     = i_reg_wdata & 8'h0f;
            `ECD_OFS_PAGE_ROM: page_rom_control_nxt = i_reg_wdata & 8'h01;
            default: begin
            end
         endcase
      end
      if (i_reg_rd) begin
         for (int n = 0; n < 4; n++) begin
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_CTRL_LOW)  rdata_nxt = area_control_low_r[n];
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_CTRL_HIGH) rdata_nxt = area_control_high_r[n];
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_START)     rdata_nxt = area_start_address_r[n];
            if (i_reg_addr == 8'(n * 4) + `ECD_OFS_MASK)      rdata_nxt = area_address_mask_r[n];
         end
         case (i_reg_addr)
            `ECD_OFS_DEF_LOW:  rdata_nxt = default_low_r;
            `ECD_OFS_DEF_HIGH: rdata_nxt = default_high_r;
            `ECD_OFS_PAGE_ROM: rdata_nxt = page_rom_control_r;
            `ECD_OFS_STATUS:   rdata_nxt = {4'h0, last_hit_r, timer_busy};
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int n = 0; n < 4; n++) begin
            area_control_low_r[n]   <= `ECD_RST_LOW;
            // Area 2 alone comes up enabled, mode bit clear
            area_control_high_r[n]  <= (n == 2) ? `ECD_RST_HIGH_AREA2 : `ECD_RST_HIGH;
            area_start_address_r[n] <= `ECD_RST_START;
            area_address_mask_r[n]  <= `ECD_RST_MASK;
         end
         default_low_r      <= `ECD_RST_LOW;
         default_high_r     <= `ECD_RST_HIGH;
         page_rom_control_r <= `ECD_RST_PAGE_ROM;
         rdata_r            <= 8'h00;
      end else begin
         for (int n = 0; n < 4; n++) begin
            area_control_low_r[n]   <= area_control_low_nxt[n];
            area_control_high_r[n]  <= area_control_high_nxt[n];
            area_start_address_r[n] <= area_start_address_nxt[n];
            area_address_mask_r[n]  <= area_address_mask_nxt[n];
         end
         default_low_r      <= default_low_nxt;
         default_high_r     <= default_high_nxt;
         page_rom_control_r <= page_rom_control_nxt;
         rdata_r            <= rdata_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_reg_rdata                   = rdata_r;
   assign o_area_chip_select_n          = area_cs_n_r;
   assign o_default_space_chip_select_n = def_cs_n_r;
   assign o_bus_16bit                   = width16_r;
   assign o_memory_type                 = mtype_r;
   assign o_page_rom_enable             = page_rom_control_r[0];
   assign o_bus_busy                    = timer_busy;
   assign o_bus_done                    = timer_done;

endmodule
`default_nettype wire

//--- verif/ecd_decoder_sva.sv
// Port-level checks for the chip select decoder
`timescale 1ns/100ps
`default_nettype none
module ecd_decoder_sva (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic       i_bus_start,
   input wire logic       i_int_io_hit,
   input wire logic       i_int_mem_hit,
   input wire logic       i_wait_n,
   input wire logic [3:0] o_area_chip_select_n,
   input wire logic       o_default_space_chip_select_n,
   input wire logic       o_bus_busy,
   input wire logic       o_bus_done
);
   logic sel_any;
   logic taken;
   assign sel_any = !(&o_area_chip_select_n) || !o_default_space_chip_select_n;
   assign taken   = i_bus_start && !o_bus_busy && !i_int_io_hit && !i_int_mem_hit;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // ********************
   // Assertions
   // ********************
   AST_ONE_SELECT: assert property (
      $countones({~o_area_chip_select_n, ~o_default_space_chip_select_n}) <= 1)
      else $error("more than one select low");
   AST_TAKEN_SELECTS: assert property (taken |=> o_bus_busy && sel_any)
      else $error("accepted cycle drove no select");
   AST_INTERNAL_NO_SELECT: assert property (
      i_bus_start && !o_bus_busy && (i_int_io_hit || i_int_mem_hit) |=> !o_bus_busy && !sel_any)
      else $error("internal hit produced an external cycle");
   AST_IDLE_RELEASED: assert property (!o_bus_busy |-> !sel_any)
      else $error("select low outside a cycle");
   AST_MIN_TWO_STATES: assert property ($rose(o_bus_busy) |-> !o_bus_done)
      else $error("bus cycle shorter than two states");
   AST_DONE_RELEASES: assert property (o_bus_done |=> !o_bus_busy && !sel_any)
      else $error("select not released after last state");
   AST_SELECT_HELD: assert property (
      o_bus_busy && !o_bus_done |=> $stable(o_area_chip_select_n)
         && $stable(o_default_space_chip_select_n))
      else $error("select changed within a cycle");
   AST_DONE_IN_CYCLE: assert property (o_bus_done |-> o_bus_busy)
      else $error("done outside a bus cycle");
   cover property (o_bus_done && !o_area_chip_select_n[1]);
   cover property (o_bus_done && !o_default_space_chip_select_n);
   cover property (o_bus_busy && !i_wait_n);
endmodule
`default_nettype wire

//--- verif/ecd_mem_model.sv
// External static memory model that stretches cycles with its wait pin
`timescale 1ns/100ps
`default_nettype none
module ecd_mem_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [3:0] i_area_chip_select_n,
   input  wire logic       i_default_space_chip_select_n,
   input  wire logic [2:0] i_hold,
   output logic            o_wait_n
);
   logic [2:0] cnt_r;
   logic       active;
   assign active = !(&i_area_chip_select_n) || !i_default_space_chip_select_n;
   // Saturates so a long hold never wraps into a short one
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 3'h0;
      end else if (!active) begin
         cnt_r <= 3'h0;
      end else if (cnt_r != 3'h7) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   // Pin is pulled up, so it reads high between cycles
   assign o_wait_n = !(active && (cnt_r < i_hold));
endmodule
`default_nettype wire

//--- verif/external_memory_chip_select_decoder_tb_top.sv
// Self-checking bench for the chip select decoder
`timescale 1ns/100ps
`default_nettype none
module external_memory_chip_select_decoder_tb_top;
   logic        clk, rst_n, wr, rd, start, bwr, io_hit, mem_hit, wait_n;
   logic        def_n, b16, prom, busy, done;
   logic [7:0]  raddr, wdata, rdata;
   logic [23:0] baddr;
   logic [3:0]  cs_n;
   logic [1:0]  mtype;
   logic [2:0]  hold;
   int          fails, samples_checked;
   logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h3};
   int          sts [5] = '{2, 3, 4, 5, 6};

   ecd_decoder dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_addr(raddr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_bus_start(start),
      .i_bus_addr(baddr), .i_bus_write(bwr), .i_int_io_hit(io_hit), .i_int_mem_hit(mem_hit),
      .i_wait_n(wait_n), .o_area_chip_select_n(cs_n), .o_default_space_chip_select_n(def_n),
      .o_bus_16bit(b16), .o_memory_type(mtype), .o_page_rom_enable(prom),
      .o_bus_busy(busy), .o_bus_done(done));
   ecd_mem_model mem (.i_clk_sys(clk), .i_rst_n(rst_n), .i_area_chip_select_n(cs_n),
      .i_default_space_chip_select_n(def_n), .i_hold(hold), .o_wait_n(wait_n));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ********************
   // Tasks
   // ********************
   task automatic stop_test();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      raddr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      raddr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("reg_rdata", rdata, e);
      // Read data stands one cycle only, then returns to zero
      @(posedge clk);
      #1;
      check("reg_rdata_idle", rdata, 8'h00);
   endtask
   // Select pattern is {default, area3..area0}, active low
   task automatic bus(input logic [23:0] a, input logic w, input logic [4:0] esel,
                      input int est, input logic e16);
      int n;
      @(posedge clk);
      baddr <= a;
      bwr <= w;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      check("select_n", {3'h0, def_n, cs_n}, {3'h0, esel});
      check("bus_16bit", {7'h0, b16}, {7'h0, e16});
      check("memory_type", {6'h0, mtype}, 8'h00);
      n = 1;
      while (done !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 20) begin
         fails++;
         stop_test();
      end
      check("states", n[7:0], est[7:0]);
      @(posedge clk);
      #1;
      check("release", {3'h0, def_n, cs_n}, 8'h1f);
   endtask
   // ********************
   // Sequence
   // ********************
   initial begin
      #(50 * 90000);
      fails++;
      stop_test();
   end
   initial begin
      {rst_n, wr, rd, start, bwr, io_hit, mem_hit} = 7'h00;
      raddr = 8'h00;
      wdata = 8'h00;
      baddr = 24'h000000;
      hold = 3'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int n = 0; n < 4; n++) begin
         rreg(8'(n * 4), 8'h22);
         rreg(8'(n * 4 + 1), (n == 2) ? 8'h80 : 8'h00);
         rreg(8'(n * 4 + 2), 8'h00);
         rreg(8'(n * 4 + 3), 8'h00);
      end
      rreg(8'h10, 8'h22);
      rreg(8'h11, 8'h00);
      rreg(8'h12, 8'h00);
      rreg(8'h20, 8'h00);
      check("page_rom", {7'h0, prom}, 8'h00);
      wreg(8'h09, 8'h80);
      bus(24'h000000, 1'b0, 5'h1b, 3, 1'b0);
      bus(24'hffffff, 1'b1, 5'h1b, 3, 1'b0);
      wreg(8'h06, 8'h11);
      wreg(8'h07, 8'h01);
      wreg(8'h05, 8'h81);
      bus(24'h110000, 1'b0, 5'h1d, 3, 1'b1);
      bus(24'h1101ff, 1'b0, 5'h1d, 3, 1'b1);
      bus(24'h110200, 1'b0, 5'h1b, 3, 1'b0);
      wreg(8'h07, 8'h03);
      bus(24'h11fe00, 1'b0, 5'h1d, 3, 1'b1);
      bus(24'h120000, 1'b0, 5'h1b, 3, 1'b0);
      wreg(8'h02, 8'h11);
      wreg(8'h01, 8'h80);
      bus(24'h110000, 1'b0, 5'h1e, 3, 1'b0);
      bus(24'h110100, 1'b0, 5'h1d, 3, 1'b1);
      // Built-in I/O, then built-in memory, both over an area 1 address
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         {io_hit, mem_hit} <= k[0] ? 2'h1 : 2'h2;
         start <= 1'b1;
         @(posedge clk);
         {io_hit, mem_hit, start} <= 3'h0;
         #1;
         check("internal_hit", {2'h0, busy, def_n, cs_n}, 8'h1f);
      end
      wreg(8'h0e, 8'h40);
      wreg(8'h0d, 8'h80);
      wreg(8'h0a, 8'h80);
      wreg(8'h09, 8'hc1);
      bus(24'h800000, 1'b0, 5'h1b, 3, 1'b1);
      bus(24'h807fff, 1'b0, 5'h1b, 3, 1'b1);
      bus(24'h808000, 1'b0, 5'h0f, 3, 1'b0);
      bus(24'h400000, 1'b1, 5'h17, 3, 1'b0);
      wreg(8'h11, 8'h01);
      for (int k = 0; k < 5; k++) begin
         wreg(8'h10, {1'b0, codes[k], 1'b0, codes[4 - k]});
         bus(24'h200000, 1'b0, 5'h0f, sts[4 - k], 1'b1);
         bus(24'h200000, 1'b1, 5'h0f, sts[k], 1'b1);
      end
      wreg(8'h10, 8'h77);
      hold <= 3'h5;
      bus(24'h200000, 1'b0, 5'h0f, 6, 1'b1);
      hold <= 3'h0;
      bus(24'h200000, 1'b1, 5'h0f, 3, 1'b1);
      wreg(8'h12, 8'h01);
      rreg(8'h12, 8'h01);
      rreg(8'h13, 8'h08);
      check("page_rom", {7'h0, prom}, 8'h01);
      stop_test();
   end
endmodule
bind ecd_decoder ecd_decoder_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
   .i_bus_start(i_bus_start), .i_int_io_hit(i_int_io_hit), .i_int_mem_hit(i_int_mem_hit),
   .i_wait_n(i_wait_n), .o_area_chip_select_n(o_area_chip_select_n),
   .o_default_space_chip_select_n(o_default_space_chip_select_n),
   .o_bus_busy(o_bus_busy), .o_bus_done(o_bus_done));
`default_nettype wire
